// *** logic/ltsc_defines.svh ***
// register offsets, field positions, reset values and timing counts for the
// lane two conditioning register group; assumes a 200 MHz core clock
`ifndef LTSC_DEFINES_SVH
`define LTSC_DEFINES_SVH

// register offsets
`define LTSC_OFS_IDLE_DETECT   8'h1c
`define LTSC_OFS_RX_BOOST      8'h1d
`define LTSC_OFS_SWING         8'h1e
`define LTSC_OFS_EMPHASIS      8'h1f

// reset values
`define LTSC_RST_IDLE_DETECT   8'h00
`define LTSC_RST_RX_BOOST      8'h2f
`define LTSC_RST_SWING         8'had
`define LTSC_RST_EMPHASIS      8'h02

// idle / detect control fields
`define LTSC_BIT_IDLE_OVR      5
`define LTSC_BIT_IDLE_MUTE     4
`define LTSC_DET_HI            3
`define LTSC_DET_LO            2

// swing control fields
`define LTSC_BIT_SHORT_PROT    7
`define LTSC_BIT_GEN12         6
`define LTSC_SWING_HI          2
`define LTSC_SWING_LO          0

// emphasis / status fields
`define LTSC_BIT_RX_FOUND      7
`define LTSC_RATE_HI           6
`define LTSC_RATE_LO           5
`define LTSC_EMPH_RSV_HI       4
`define LTSC_EMPH_HI           2
`define LTSC_EMPH_LO           0

// detect codes and detected-rate codes
`define LTSC_DET_HIZ           2'h0
`define LTSC_DET_LIMITED       2'h1
`define LTSC_DET_ENDLESS       2'h2
`define LTSC_DET_FIXED50       2'h3
`define LTSC_RATE_GEN3         2'h3

// timing
`define LTSC_CLK_MHZ           200
`define LTSC_PROBE_PERIOD_MS   12
`define LTSC_PROBE_LIMIT_MS    600
`define LTSC_PROBE_PERIOD_CYC  (`LTSC_PROBE_PERIOD_MS * 1000 * `LTSC_CLK_MHZ)
`define LTSC_PROBE_ATTEMPTS    (`LTSC_PROBE_LIMIT_MS / `LTSC_PROBE_PERIOD_MS)

`endif

// *** logic/ltsc_pkg.sv ***
// types shared by the lane two conditioning register group
// assumes ltsc_defines.svh for all numeric constants
package ltsc_pkg;

  typedef logic [7:0] ltsc_byte_t;
  typedef logic [1:0] ltsc_det_code_t;
  typedef logic [1:0] ltsc_rate_t;
  typedef logic [2:0] ltsc_level_t;

  typedef enum logic [2:0] {
    LTSC_PR_OFF,
    LTSC_PR_WAIT,
    LTSC_PR_FOUND,
    LTSC_PR_GAVE_UP,
    LTSC_PR_FIXED
  } ltsc_probe_state_e;

endpackage

// *** logic/ltsc_rx_probe.sv ***
// far-end receiver detect sequencer for one lane
// assumes probe_hit is already synchronised to clk and settles within one period
`timescale 1ns/1ps
`include "ltsc_defines.svh"

module ltsc_rx_probe
  import ltsc_pkg::*;
#(
  parameter int PERIOD_CYCLES = `LTSC_PROBE_PERIOD_CYC
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // control
  input  wire ltsc_det_code_t det_code,
  input  wire logic           probe_hit,
  // results
  output logic                probe_start_q,
  output logic                found_q,
  output logic                term_50_q
);

  localparam logic [31:0] PERIOD_LAST = 32'(PERIOD_CYCLES - 1);
  localparam logic [5:0]  ATTEMPTS    = 6'(`LTSC_PROBE_ATTEMPTS);

  ltsc_probe_state_e state_q;
  ltsc_det_code_t    code_q;
  logic [31:0]       timer_q;
  logic [5:0]        tries_q;
  logic              tick;
  logic              restart;

  assign tick    = (timer_q == PERIOD_LAST);
  // any change of the detect code starts the sequence over
  assign restart = (det_code != code_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_q <= `LTSC_DET_HIZ;
    end else begin
      code_q <= det_code;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_q <= 32'h0;
    end else if (restart || tick) begin
      timer_q <= 32'h0;
    end else begin
      timer_q <= timer_q + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q       <= LTSC_PR_OFF;
      tries_q       <= 6'h0;
      probe_start_q <= 1'b0;
    end else if (restart) begin
      tries_q       <= 6'h0;
      probe_start_q <= 1'b0;
      case (det_code)
        `LTSC_DET_HIZ:     state_q <= LTSC_PR_OFF;
        `LTSC_DET_FIXED50: state_q <= LTSC_PR_FIXED;
        default:           state_q <= LTSC_PR_WAIT;
      endcase
    end else begin
      probe_start_q <= 1'b0;
      case (state_q)
        LTSC_PR_WAIT: begin
          if (tick) begin
            // the previous attempt's answer is judged before a new one goes out
            if (tries_q != 6'h0 && probe_hit) begin
              state_q <= LTSC_PR_FOUND;
            end else if (code_q == `LTSC_DET_LIMITED && tries_q == ATTEMPTS) begin
              state_q <= LTSC_PR_GAVE_UP;
            end else begin
              probe_start_q <= 1'b1;
              if (tries_q != ATTEMPTS) begin
                tries_q <= tries_q + 6'h1;
              end
            end
          end
        end
        LTSC_PR_OFF, LTSC_PR_FOUND, LTSC_PR_GAVE_UP, LTSC_PR_FIXED: begin
          state_q <= state_q;
        end
        default: state_q <= LTSC_PR_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      found_q   <= 1'b0;
      term_50_q <= 1'b0;
    end else begin
      found_q   <= (state_q == LTSC_PR_FOUND) && !restart;
      // high impedance until found, then 50 ohm; the fixed code gives 50 ohm at once
      term_50_q <= !restart &&
                   (state_q == LTSC_PR_FOUND || state_q == LTSC_PR_FIXED);
    end
  end

endmodule

// *** logic/ltsc_lane_regs.sv ***
// lane two conditioning register group: four byte registers reached through the
// register port of the serial slave engine or the configuration loader
// assumes that port is on clk; pins and analog status arrive asynchronously
`timescale 1ns/1ps
`include "ltsc_defines.svh"

//Contract
// - idle override bit set: mute from force-mute bit, else automatic idle detect.
// - under override, force-mute 1 mutes output, 0 leaves output active.
// - detect code 00 keeps input high impedance; 11 gives fixed 50 ohm.
// - code 01 probes every 12 ms, gives up after fifty attempts.
// - code 10 probes every 12 ms without limit until found.
// - automatic codes keep high impedance until found, then 50 ohm.
// - register detect field takes precedence over the detect configuration pin; until the first idle register write the pin decides.
// - receive boost is an eight-bit level, reset value 0x2f.
// - swing register bit 7 enables output short-circuit protection.
// - generation bit overrides mode pin: 1 first/second gen, 0 third gen; until the first swing register write the mode pins decide.
// - three-bit swing code selects 0.7 V to 1.4 V, default 101.
// - read-only emphasis bit 7 shows a far-end receiver was found.
// - detected-rate field: 00 first, 01 second, 11 third generation.
// - detected rate updates only while the mode pin is automatic.
// - three-bit de-emphasis code, 000 is 0 dB, default 010.
module ltsc_lane_regs
  import ltsc_pkg::*;
#(
  parameter int PROBE_PERIOD_CYCLES = `LTSC_PROBE_PERIOD_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire ltsc_byte_t reg_addr,
  input  wire logic       reg_wr,
  input  wire ltsc_byte_t reg_wdata,
  input  wire logic       reg_rd,
  output ltsc_byte_t      reg_rdata,
  // configuration pins
  input  wire logic [1:0] rx_detect_pin,
  input  wire logic       mode_pin_auto,
  input  wire logic       mode_pin_gen12,
  // analog lane status
  input  wire logic       auto_idle_in,
  input  wire logic       probe_hit_in,
  input  wire logic [1:0] gen_rate_detected_in,
  // analog lane controls
  output logic            output_mute,
  output logic            input_term_50,
  output logic            probe_start,
  output ltsc_byte_t      rx_boost_level,
  output ltsc_level_t     output_swing_level,
  output logic            short_prot_en,
  output logic            gen12_sel,
  output ltsc_level_t     tx_emphasis_level
);

  // register select codes
  localparam logic [2:0] SEL_NONE  = 3'h0;
  localparam logic [2:0] SEL_IDLE  = 3'h1;
  localparam logic [2:0] SEL_BOOST = 3'h2;
  localparam logic [2:0] SEL_SWING = 3'h3;
  localparam logic [2:0] SEL_EMPH  = 3'h4;

  // reset images of single fields: swing, protection and emphasis codes for their outputs, reserved and rate bits for storage
  localparam ltsc_level_t RST_SWING_CODE = 3'(`LTSC_RST_SWING);
  localparam logic        RST_SHORT_PROT = 1'(`LTSC_RST_SWING >> `LTSC_BIT_SHORT_PROT);
  localparam ltsc_level_t RST_EMPH_CODE  = 3'(`LTSC_RST_EMPHASIS);
  localparam logic [1:0]  RST_EMPH_RSV   = 2'(`LTSC_RST_EMPHASIS >> (`LTSC_EMPH_RSV_HI - 1));
  localparam ltsc_rate_t  RST_RATE       = 2'(`LTSC_RST_EMPHASIS >> `LTSC_RATE_LO);

  function automatic logic [2:0] reg_sel(input ltsc_byte_t addr);
    case (addr)
      `LTSC_OFS_IDLE_DETECT: reg_sel = SEL_IDLE;
      `LTSC_OFS_RX_BOOST:    reg_sel = SEL_BOOST;
      `LTSC_OFS_SWING:       reg_sel = SEL_SWING;
      `LTSC_OFS_EMPHASIS:    reg_sel = SEL_EMPH;
      default:               reg_sel = SEL_NONE;
    endcase
  endfunction

  // storage
  ltsc_byte_t     idle_q;
  ltsc_byte_t     boost_q;
  ltsc_byte_t     swing_q;
  logic [1:0]     emph_rsv_q;
  ltsc_level_t    emph_q;
  ltsc_rate_t     rate_q;
  logic           det_written_q;
  logic           gen_written_q;
  ltsc_det_code_t det_code_q;

  // synchronised pins and analog status
  logic [7:0]     pin_meta_q;
  logic [7:0]     pin_sync_q;
  logic [1:0]     det_pin_s;
  logic           mode_auto_s;
  logic           mode_gen12_s;
  logic           auto_idle_s;
  logic           probe_hit_s;
  ltsc_rate_t     rate_s;
  logic [7:0]     pin_raw;

  // detect sequencer results
  logic           rx_found;
  logic           term_50;
  logic           probe_pulse;

  logic [2:0]     wr_sel;
  logic [2:0]     rd_sel;

  // a write and a read in one cycle: the read returns the old contents
  assign wr_sel = reg_wr ? reg_sel(reg_addr) : SEL_NONE;
  assign rd_sel = reg_sel(reg_addr);

  assign pin_raw = {rx_detect_pin, mode_pin_auto, mode_pin_gen12,
                    auto_idle_in, probe_hit_in, gen_rate_detected_in};

  // every asynchronous input passes two stages before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign det_pin_s    = pin_sync_q[7:6];
  assign mode_auto_s  = pin_sync_q[5];
  assign mode_gen12_s = pin_sync_q[4];
  assign auto_idle_s  = pin_sync_q[3];
  assign probe_hit_s  = pin_sync_q[2];
  assign rate_s       = pin_sync_q[1:0];

  // idle / detect control register, stored whole
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_q <= `LTSC_RST_IDLE_DETECT;
    end else if (wr_sel == SEL_IDLE) begin
      idle_q <= reg_wdata;
    end
  end

  // the pin steers detection only until software first writes the field;
  // the reset value alone would otherwise silence the pin for good
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_written_q <= 1'b0;
    end else if (wr_sel == SEL_IDLE) begin
      det_written_q <= 1'b1;
    end
  end

  // the sequencer sees a code change one stage later and starts over
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_code_q <= `LTSC_DET_HIZ;
    end else if (det_written_q) begin
      det_code_q <= idle_q[`LTSC_DET_HI:`LTSC_DET_LO];
    end else begin
      det_code_q <= det_pin_s;
    end
  end

  // receive boost level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boost_q <= `LTSC_RST_RX_BOOST;
    end else if (wr_sel == SEL_BOOST) begin
      boost_q <= reg_wdata;
    end
  end

  // swing control; reserved bits are kept as written, software keeps them at 101
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swing_q <= `LTSC_RST_SWING;
    end else if (wr_sel == SEL_SWING) begin
      swing_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen_written_q <= 1'b0;
    end else if (wr_sel == SEL_SWING) begin
      gen_written_q <= 1'b1;
    end
  end

  // emphasis register: only reserved and emphasis fields take writes
  // bits 7:5 are status and are rebuilt on every read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      emph_rsv_q <= RST_EMPH_RSV;
      emph_q     <= RST_EMPH_CODE;
    end else if (wr_sel == SEL_EMPH) begin
      emph_rsv_q <= reg_wdata[`LTSC_EMPH_RSV_HI:`LTSC_EMPH_RSV_HI-1];
      emph_q     <= reg_wdata[`LTSC_EMPH_HI:`LTSC_EMPH_LO];
    end
  end

  // detected rate holds its last value while the mode pin is strapped
  // so a strapped part reports a stale rate, by intent
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_q <= RST_RATE;
    end else if (mode_auto_s) begin
      rate_q <= rate_s;
    end
  end

  ltsc_rx_probe #(
    .PERIOD_CYCLES (PROBE_PERIOD_CYCLES)
  ) u_probe (
    .clk           (clk),
    .rst           (rst),
    .det_code      (det_code_q),
    .probe_hit     (probe_hit_s),
    .probe_start_q (probe_pulse),
    .found_q       (rx_found),
    .term_50_q     (term_50)
  );

  // read data, one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (rd_sel)
        SEL_IDLE:  reg_rdata <= idle_q;
        SEL_BOOST: reg_rdata <= boost_q;
        SEL_SWING: reg_rdata <= swing_q;
        SEL_EMPH:  reg_rdata <= {rx_found, rate_q, emph_rsv_q, emph_q};
        default:   reg_rdata <= 8'h00;
      endcase
    end
  end

  // output mute: override bit selects the force-mute bit over auto detect
  // auto idle reaches output_mute three clocks after its pin: two synchroniser stages and this flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_mute <= 1'b0;
    end else if (idle_q[`LTSC_BIT_IDLE_OVR]) begin
      output_mute <= idle_q[`LTSC_BIT_IDLE_MUTE];
    end else begin
      output_mute <= auto_idle_s;
    end
  end

  // termination and probe strobe, one stage after the sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      input_term_50 <= 1'b0;
      probe_start   <= 1'b0;
    end else begin
      input_term_50 <= term_50;
      probe_start   <= probe_pulse;
    end
  end

  // boost leaves through a flop so the lane never sees a partial update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_boost_level <= `LTSC_RST_RX_BOOST;
    end else begin
      rx_boost_level <= boost_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_swing_level <= RST_SWING_CODE;
      short_prot_en      <= RST_SHORT_PROT;
    end else begin
      output_swing_level <= swing_q[`LTSC_SWING_HI:`LTSC_SWING_LO];
      short_prot_en      <= swing_q[`LTSC_BIT_SHORT_PROT];
    end
  end

  // generation: written register bit wins, else strap or auto detected rate
  // a strap change alone never undoes a written generation bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen12_sel <= 1'b0;
    end else if (gen_written_q) begin
      gen12_sel <= swing_q[`LTSC_BIT_GEN12];
    end else if (mode_auto_s) begin
      gen12_sel <= (rate_q != `LTSC_RATE_GEN3);
    end else begin
      gen12_sel <= mode_gen12_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_emphasis_level <= RST_EMPH_CODE;
    end else begin
      tx_emphasis_level <= emph_q;
    end
  end

endmodule

// *** bench/ltsc_lane_regs_asserts.sv ***
// checker for the lane two conditioning register group
// assumes the register port and all watched outputs share clk
`timescale 1ns/1ps
module ltsc_lane_regs_chk
  import ltsc_pkg::*;
#(
  parameter int PROBE_PERIOD_CYCLES = 20
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register port
  input wire ltsc_byte_t  reg_addr,
  input wire logic        reg_wr,
  input wire ltsc_byte_t  reg_wdata,
  input wire logic        reg_rd,
  input wire ltsc_byte_t  reg_rdata,
  // lane controls
  input wire logic        output_mute,
  input wire logic        input_term_50,
  input wire logic        probe_start,
  input wire ltsc_byte_t  rx_boost_level,
  input wire ltsc_level_t output_swing_level,
  input wire logic        short_prot_en,
  input wire logic        gen12_sel,
  input wire ltsc_level_t tx_emphasis_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [31:0] gap_q;
  logic        run_q;
  logic [7:0]  cnt_q;
  logic        lim_q;
  logic        det_wr;
  assign det_wr = reg_wr && reg_addr == 8'h1c;

  // a detect write restarts the sequence, so the gap check skips it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) gap_q <= 32'h0;
    else if (probe_start) gap_q <= 32'h1;
    else gap_q <= gap_q + 32'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) run_q <= 1'b0;
    else if (det_wr) run_q <= 1'b0;
    else if (probe_start) run_q <= 1'b1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_q <= 8'h00;
    else if (det_wr) cnt_q <= 8'h00;
    else if (probe_start) cnt_q <= cnt_q + 8'h01;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lim_q <= 1'b0;
    else if (det_wr) lim_q <= reg_wdata[3:2] == 2'h1;
  end

  sequence s_wr(a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_det(c);
    s_wr(8'h1c) ##0 reg_wdata[3:2] == c;
  endsequence

  a_boost_write: assert property (
    s_wr(8'h1d) |-> ##2 rx_boost_level == $past(reg_wdata, 2)) else $error("boost level");
  a_boost_readback: assert property (
    s_wr(8'h1d) ##2 (reg_rd && reg_addr == 8'h1d) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("boost readback");
  a_swing_fields: assert property (
    s_wr(8'h1e) |-> ##2 output_swing_level == $past(reg_wdata[2:0], 2)
      && short_prot_en == $past(reg_wdata[7], 2) && gen12_sel == $past(reg_wdata[6], 2))
    else $error("swing fields");
  a_emph_write: assert property (
    s_wr(8'h1f) |-> ##2 tx_emphasis_level == $past(reg_wdata[2:0], 2)) else $error("emphasis");
  a_mute_override: assert property (
    s_wr(8'h1c) ##0 reg_wdata[5] |-> ##3 output_mute == $past(reg_wdata[4], 3))
    else $error("mute override");
  a_term_fixed: assert property (
    s_det(2'h3) |-> ##5 input_term_50) else $error("fixed termination");
  a_term_hiz: assert property (
    s_det(2'h0) |-> ##4 !input_term_50 [*3]) else $error("high impedance");
  a_probe_pulse: assert property (
    probe_start |=> !probe_start) else $error("probe pulse width");
  a_probe_period: assert property (
    probe_start && run_q |-> gap_q == PROBE_PERIOD_CYCLES) else $error("probe period");
  a_probe_limit: assert property (
    lim_q |-> cnt_q <= 8'd50) else $error("probe limit");
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
endmodule

bind ltsc_lane_regs ltsc_lane_regs_chk #(.PROBE_PERIOD_CYCLES(PROBE_PERIOD_CYCLES)) chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .output_mute(output_mute),
  .input_term_50(input_term_50), .probe_start(probe_start), .rx_boost_level(rx_boost_level),
  .output_swing_level(output_swing_level), .short_prot_en(short_prot_en),
  .gen12_sel(gen12_sel), .tx_emphasis_level(tx_emphasis_level));

// *** bench/ltsc_host_model.sv ***
// register host model: single byte writes and reads on the register port
// assumes the port samples strobes on the rising clk edge
`timescale 1ns/1ps
module ltsc_host_model
  import ltsc_pkg::*;
(
  // clock
  input  wire logic       clk,
  // register port
  output ltsc_byte_t      reg_addr = 8'h00,
  output logic            reg_wr = 1'b0,
  output ltsc_byte_t      reg_wdata = 8'h00,
  output logic            reg_rd = 1'b0,
  input  wire ltsc_byte_t reg_rdata
);
  task automatic wr(input ltsc_byte_t a, input ltsc_byte_t d);
    ltsc_byte_t v;
    v = d;
    if (a == 8'h1e) v[5:3] = 3'b101;
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // released lines must not look like the last transfer
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask

  task automatic rd(input ltsc_byte_t a, output ltsc_byte_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the lane two conditioning register group
// assumes a shortened probe period and pins settling within six clocks
`timescale 1ns/1ps
module testbench;
  import ltsc_pkg::*;
  localparam int PER = 20;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  ltsc_byte_t  reg_addr, reg_wdata, reg_rdata, boost, d;
  logic        reg_wr, reg_rd, mute, term, pstart, sprot, gen12;
  logic [1:0]  det_pin = 2'h3;
  logic        mode_auto = 1'b1;
  logic        mode_gen12 = 1'b0;
  logic        idle = 1'b0;
  logic        hit = 1'b0;
  logic [1:0]  rate = 2'h0;
  ltsc_level_t swing, emph;
  int          num_errors = 0;
  int          check_count = 0;

  always #2.5 clk = ~clk;

  ltsc_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ltsc_lane_regs #(.PROBE_PERIOD_CYCLES(PER)) uut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_detect_pin(det_pin), .mode_pin_auto(mode_auto),
    .mode_pin_gen12(mode_gen12), .auto_idle_in(idle), .probe_hit_in(hit),
    .gen_rate_detected_in(rate), .output_mute(mute), .input_term_50(term),
    .probe_start(pstart), .rx_boost_level(boost), .output_swing_level(swing),
    .short_prot_en(sprot), .gen12_sel(gen12), .tx_emphasis_level(emph));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input ltsc_byte_t got, input ltsc_byte_t exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input ltsc_byte_t a, input ltsc_byte_t exp);
    host.rd(a, d);
    cmp(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // counts probe pulses, sampled away from the launching edge
  task automatic count(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(negedge clk);
      if (pstart === 1'b1) k++;
    end
    @(posedge clk);
  endtask

  task automatic t_reset();
    rdc(8'h1c, 8'h00);
    rdc(8'h1d, 8'h2f);
    rdc(8'h1e, 8'had);
    rdc(8'h1f, 8'h02);
    rdc(8'h1b, 8'h00);
    cmp(boost, 8'h2f);
    cmp({5'h0, swing}, 8'h05);
    cmp({5'h0, emph}, 8'h02);
    cmp({7'h0, sprot}, 8'h01);
    $display("test reset done");
  endtask

  task automatic t_pin();
    cyc(4);
    cmp({7'h0, term}, 8'h01);
    rate <= 2'h1;
    cyc(6);
    rdc(8'h1f, 8'h22);
    rate <= 2'h3;
    cyc(6);
    rdc(8'h1f, 8'h62);
    mode_auto <= 1'b0;
    cyc(6);
    rate <= 2'h0;
    mode_gen12 <= 1'b1;
    cyc(6);
    rdc(8'h1f, 8'h62);
    cmp({7'h0, gen12}, 8'h01);
    host.wr(8'h1c, 8'h00);
    cyc(4);
    cmp({7'h0, term}, 8'h00);
    host.wr(8'h1c, 8'h0c);
    cyc(6);
    cmp({7'h0, term}, 8'h01);
    $display("test pin done");
  endtask

  task automatic t_rw();
    host.wr(8'h1d, 8'ha5);
    rdc(8'h1d, 8'ha5);
    cmp(boost, 8'ha5);
    host.wr(8'h1e, 8'h47);
    rdc(8'h1e, 8'h6f);
    cmp({5'h0, swing}, 8'h07);
    cmp({7'h0, sprot}, 8'h00);
    cmp({7'h0, gen12}, 8'h01);
    host.wr(8'h1e, 8'h80);
    rdc(8'h1e, 8'ha8);
    cmp({7'h0, gen12}, 8'h00);
    cmp({7'h0, sprot}, 8'h01);
    host.wr(8'h1f, 8'hff);
    rdc(8'h1f, 8'h7f);
    cmp({5'h0, emph}, 8'h07);
    host.wr(8'h20, 8'hff);
    rdc(8'h20, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_mute();
    idle <= 1'b1;
    cyc(6);
    cmp({7'h0, mute}, 8'h01);
    host.wr(8'h1c, 8'h20);
    cyc(4);
    cmp({7'h0, mute}, 8'h00);
    host.wr(8'h1c, 8'h30);
    idle <= 1'b0;
    cyc(6);
    cmp({7'h0, mute}, 8'h01);
    host.wr(8'h1c, 8'h00);
    cyc(4);
    cmp({7'h0, mute}, 8'h00);
    $display("test mute done");
  endtask

  task automatic t_probe();
    int k;
    host.wr(8'h1c, 8'h08);
    count(55 * PER, k);
    cmp({7'h0, k > 50}, 8'h01);
    cmp({7'h0, term}, 8'h00);
    hit <= 1'b1;
    for (int i = 0; i < 3 * PER && term !== 1'b1; i++) @(posedge clk);
    if (term !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
    host.rd(8'h1f, d);
    cmp(d & 8'h80, 8'h80);
    hit <= 1'b0;
    host.wr(8'h1c, 8'h04);
    count(55 * PER, k);
    cmp(8'(k), 8'd50);
    cmp({7'h0, term}, 8'h00);
    host.rd(8'h1f, d);
    cmp(d & 8'h80, 8'h00);
    $display("test probe done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pin();
    t_rw();
    t_mute();
    t_probe();
    end_of_test();
  end
endmodule
